// *** hw/debug_unit_defines.svh ***
// Constants for the debug control unit: selectors, field positions, codes.
// Assumes inclusion by bare name from the package and the design modules.
// Overview of operation
// - Breakpoint registers on primary 14, secondary 8/9/0/3/4
// - Debug registers on primary 8..14, secondary 0
// - Data-operation form on debug coprocessor traps undefined
// - User-mode access traps undefined; privileged only
// - Test port reaches transmit, receive and control/status
// - Control/status shared by software and test port
// - Halt mode: reset vector, debug mode 0x15
// - Halt exception enters debug mode via reset vector
// - Halt mode allows handler download into cache
// - Monitor exception enters abort, prefetch or data vector
// - Global enable bit 31, software writable, resets 0
// - Halt bit 30, test port writable, test reset clears
// - Bit 29 reads the system break input level
// - Vector traps 23/22/20..16 test-port writable, test reset clears
// - Entry cause bits 4:2 record latest debug exception
// - Global disable ignores breaks except reset trap
// - Trace runs with enable and global; exception clears
// - Vector trap acts as breakpoint on vector
`ifndef DEBUG_UNIT_DEFINES_SVH
`define DEBUG_UNIT_DEFINES_SVH
`define CP_DEBUG_NUM 4'he
`define CP_SYSTEM_NUM 4'hf
`define SEL_TX 4'h8
`define SEL_RX 4'h9
`define SEL_DEBUG_CONTROL_STATUS 4'ha
`define SEL_TRACE 4'hb
`define SEL_CHK0 4'hc
`define SEL_CHK1 4'hd
`define SEL_TXRX_CTRL 4'he
`define SEL_BREAK_PRI 4'he
`define SEL_IBR0 4'h8
`define SEL_IBR1 4'h9
`define SEL_DATA_BREAK_REG_ZERO 4'h0
`define SEL_DATA_BREAK_REG_ONE 4'h3
`define SEL_DATA_BREAK_CONTROL 4'h4
`define SEL_ZERO 4'h0
`define BIT_GE 31
`define BIT_HALT 30
`define BIT_SOC 29
`define BIT_TF 23
`define BIT_TI 22
`define BIT_TD 20
`define BIT_TA 19
`define BIT_TS 18
`define BIT_TU 17
`define BIT_TR 16
`define BIT_SA 5
`define BIT_M 1
`define BIT_E 0
`define MODE_USER 5'h10
`define MODE_DEBUG 5'h15
`define MODE_ABORT 5'h17
`define VEC_RESET 5'h00
`define VEC_PABORT 5'h0c
`define VEC_DABORT 5'h10
`define MOE_RESET 3'h0
`define MOE_IBRK 3'h1
`define MOE_DBRK 3'h2
`define MOE_BKPT 3'h3
`define MOE_EXT 3'h4
`define MOE_VTRAP 3'h5
`define MOE_TBFULL 3'h6
`define VIDX_RESET 3'h0
`define VIDX_UNDEF 3'h1
`define VIDX_SWI 3'h2
`define VIDX_PABORT 3'h3
`define VIDX_DABORT 3'h4
`define VIDX_IRQ 3'h6
`define VIDX_FIQ 3'h7
`endif

// *** hw/debug_unit_pkg.sv ***
// Types shared by the debug control unit and its bench.
// Assumes the defines header is on the include path.
`include "debug_unit_defines.svh"
package debug_unit_pkg;
    // Form of a coprocessor instruction presented to the unit
    typedef enum logic [2:0] {
        CP_READ,
        CP_WRITE,
        CP_LOAD,
        CP_STORE,
        CP_DATA_OP
    } cp_op_t;
    // Target of a test port write
    typedef enum logic {
        TP_TO_DEBUG_CONTROL_STATUS,
        TP_TO_RX
    } tp_target_t;
endpackage : debug_unit_pkg

// *** hw/word_handshake.sv ***
// Toggle handshake carrying one word from a source clock to a destination.
// Assumes the source holds off while busy; each side has its own reset.
`timescale 1ns/1ps
module word_handshake #(
    parameter int W = 32
) (
    input wire logic src_clk,
    input wire logic src_reset,
    input wire logic src_en,
    input wire logic src_send,
    input wire logic [W-1:0] src_data,
    output logic src_busy,
    input wire logic dst_clk,
    input wire logic dst_reset,
    input wire logic dst_en,
    output logic dst_valid,
    output logic [W-1:0] dst_data
);
    logic [W-1:0] hold; // Word kept stable while in flight
    logic req; // Request toggle, source domain
    logic ack; // Acknowledge toggle, destination domain
    logic ack_s1, ack_s2, ack_s3; // Acknowledge synchroniser
    logic req_s1, req_s2, req_s3; // Request synchroniser

    // Source: launch a word and wait for the returning toggle
    always_ff @(posedge src_clk) begin
        if (src_reset) begin
            hold <= '0;
            req <= 1'b0;
            src_busy <= 1'b0;
        end else if (src_en) begin
            if (src_send && !src_busy) begin
                hold <= src_data;
                req <= ~req;
                src_busy <= 1'b1;
            end else if (ack_s2 != ack_s3) begin
                src_busy <= 1'b0;
            end
        end
    end

    // Source: bring the acknowledge across
    always_ff @(posedge src_clk) begin
        if (src_reset) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else if (src_en) begin
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    // Destination: bring the request across and answer it
    // No reset here: clearing the chain alone would invent a toggle and
    // replay the last word; a word arriving during reset is dropped instead
    always_ff @(posedge dst_clk) begin
        if (dst_en) begin
            req_s1 <= req;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            ack <= req_s2;
        end
    end

    // Destination: capture the settled word
    always_ff @(posedge dst_clk) begin
        if (dst_reset) begin
            dst_valid <= 1'b0;
            dst_data <= '0;
        end else if (dst_en) begin
            dst_valid <= (req_s2 != req_s3);
            if (req_s2 != req_s3) begin
                dst_data <= hold;
            end
        end
    end
endmodule : word_handshake

// *** hw/debug_control_unit.sv ***
// Debug control unit: register decode, control/status word, exceptions.
// Assumes a core that presents coprocessor accesses and debug events on
// clk, and a test port that runs on its own clock tck.
`timescale 1ns/1ps
`include "debug_unit_defines.svh"
module debug_control_unit
    import debug_unit_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic cp_valid,
    input wire logic [3:0] cp_num,
    input wire cp_op_t cp_op,
    input wire logic [3:0] cp_primary,
    input wire logic [3:0] cp_secondary,
    input wire logic [31:0] cp_wdata,
    input wire logic [4:0] cur_mode,
    output logic cp_done,
    output logic cp_undef,
    output logic [31:0] cp_rdata,
    input wire logic insn_break_hit,
    input wire logic data_break_hit,
    input wire logic bkpt_insn,
    input wire logic trace_full,
    input wire logic sds_data_abort,
    input wire logic vec_fetch,
    input wire logic [2:0] vec_index,
    input wire logic soc_break,
    output logic exc_take,
    output logic [4:0] exc_mode,
    output logic [4:0] exc_vector,
    output logic trace_run,
    output logic cache_download_en,
    input wire logic tck,
    input wire logic tp_reset,
    input wire logic tp_write,
    input wire tp_target_t tp_target,
    input wire logic [31:0] tp_wdata,
    output logic tp_busy,
    output logic tp_view_valid,
    output logic [31:0] tp_debug_control_status,
    output logic [31:0] tp_tx
);
    // Control/status fields
    logic ge, halt, soc_level, sticky_abort, tb_mode, tb_en;
    logic trap_fiq, trap_irq, trap_dab, trap_pab, trap_swi, trap_und, trap_rst;
    logic [2:0] moe;
    logic [31:0] debug_control_status_word; // Assembled control/status word
    // Other debug registers
    logic [31:0] ibr0, ibr1, data_break_reg_zero, data_break_reg_one, data_break_control, chk0, chk1, tx, rx, txrx_ctrl;
    // Synchronisers for pins from outside the clk domain
    logic trst_s1, trst_s2, soc_s1, soc_s2, soc_s3;
    logic core_link_reset; // Clears the link crossings on either reset
    // Test port write crossing
    logic wr_valid;
    logic [32:0] wr_word;
    // Status view crossing
    logic view_busy;
    logic [63:0] view_word;
    // Access decode
    logic is_wr, is_rd, sel_dbg, sel_brk, privileged, in_debug, acc_undef;
    logic sw_debug_control_status_wr;
    logic [31:0] rd_mux;
    // Exception decode
    logic vt_hit, soc_edge, any_exc;
    logic [2:0] next_moe;

    assign debug_control_status_word = {ge, halt, soc_level, 5'h00, trap_fiq, trap_irq, 1'b0,
                        trap_dab, trap_pab, trap_swi, trap_und, trap_rst,
                        10'h000, sticky_abort, moe, tb_mode, tb_en};

    // Pin synchronisers: logic reads the second stage, and the third for the break edge
    always_ff @(posedge clk) begin
        if (reset) begin
            trst_s1 <= 1'b0;
            trst_s2 <= 1'b0;
            soc_s1 <= 1'b0;
            soc_s2 <= 1'b0;
            soc_s3 <= 1'b0;
        end else if (ce) begin
            trst_s1 <= tp_reset;
            trst_s2 <= trst_s1;
            soc_s1 <= soc_break;
            soc_s2 <= soc_s1;
            soc_s3 <= soc_s2;
        end
    end
    assign core_link_reset = reset || trst_s2;
    assign soc_edge = soc_s2 && !soc_s3;

    // Test port writes reach the core through a handshake
    word_handshake #(.W(33)) u_tp_write (
        .src_clk(tck),
        .src_reset(tp_reset),
        .src_en(1'b1),
        .src_send(tp_write),
        .src_data({tp_target == TP_TO_RX, tp_wdata}),
        .src_busy(tp_busy),
        .dst_clk(clk),
        .dst_reset(core_link_reset),
        .dst_en(ce),
        .dst_valid(wr_valid),
        .dst_data(wr_word)
    );

    // Status and transmit words return to the test port continuously
    word_handshake #(.W(64)) u_tp_view (
        .src_clk(clk),
        .src_reset(core_link_reset),
        .src_en(ce),
        .src_send(!view_busy),
        .src_data({tx, debug_control_status_word}),
        .src_busy(view_busy),
        .dst_clk(tck),
        .dst_reset(tp_reset),
        .dst_en(1'b1),
        .dst_valid(tp_view_valid),
        .dst_data(view_word)
    );
    assign tp_debug_control_status = view_word[31:0];
    assign tp_tx = view_word[63:32];

    // Access decode
    assign is_wr = (cp_op == CP_WRITE) || (cp_op == CP_LOAD);
    assign is_rd = (cp_op == CP_READ) || (cp_op == CP_STORE);
    assign sel_dbg = (cp_num == `CP_DEBUG_NUM);
    assign sel_brk = (cp_num == `CP_SYSTEM_NUM) && (cp_primary == `SEL_BREAK_PRI);
    assign privileged = (cur_mode != `MODE_USER);
    assign in_debug = (cur_mode == `MODE_DEBUG);

    // Trap cases: data operations, user mode, halt mode outside debug mode
    always_comb begin
        acc_undef = 1'b0;
        if (sel_dbg && cp_op == CP_DATA_OP) begin
            acc_undef = 1'b1;
        end else if ((sel_dbg || sel_brk) && !privileged) begin
            acc_undef = 1'b1;
        end else if (halt && !in_debug && (sel_brk ||
                     (sel_dbg && cp_primary == `SEL_DEBUG_CONTROL_STATUS))) begin
            acc_undef = 1'b1;
        end
    end
    assign sw_debug_control_status_wr = cp_valid && !acc_undef && is_wr && sel_dbg &&
                        cp_primary == `SEL_DEBUG_CONTROL_STATUS && cp_secondary == `SEL_ZERO;

    // Read selection; opcode sub-fields are not part of the decode
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_dbg && cp_secondary == `SEL_ZERO) begin
            case (cp_primary)
                `SEL_TX: rd_mux = tx;
                `SEL_RX: rd_mux = rx;
                `SEL_DEBUG_CONTROL_STATUS: rd_mux = debug_control_status_word;
                `SEL_CHK0: rd_mux = chk0;
                `SEL_CHK1: rd_mux = chk1;
                `SEL_TXRX_CTRL: rd_mux = txrx_ctrl;
                default: rd_mux = 32'h0000_0000;
            endcase
        end else if (sel_brk) begin
            case (cp_secondary)
                `SEL_IBR0: rd_mux = ibr0;
                `SEL_IBR1: rd_mux = ibr1;
                `SEL_DATA_BREAK_REG_ZERO: rd_mux = data_break_reg_zero;
                `SEL_DATA_BREAK_REG_ONE: rd_mux = data_break_reg_one;
                `SEL_DATA_BREAK_CONTROL: rd_mux = data_break_control;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Access answer one cycle after the request
    always_ff @(posedge clk) begin
        if (reset) begin
            cp_done <= 1'b0;
            cp_undef <= 1'b0;
            cp_rdata <= 32'h0000_0000;
        end else if (ce) begin
            cp_done <= cp_valid;
            cp_undef <= cp_valid && acc_undef;
            cp_rdata <= (cp_valid && is_rd && !acc_undef) ? rd_mux : 32'h0000_0000;
        end
    end

    // Software writes to plain debug registers; receive only from test port
    always_ff @(posedge clk) begin
        if (reset) begin
            {ibr0, ibr1, data_break_reg_zero, data_break_reg_one, data_break_control} <= '0;
            {chk0, chk1, tx, rx, txrx_ctrl} <= '0;
        end else if (ce) begin
            if (cp_valid && !acc_undef && is_wr && sel_brk) begin
                case (cp_secondary)
                    `SEL_IBR0: ibr0 <= cp_wdata;
                    `SEL_IBR1: ibr1 <= cp_wdata;
                    `SEL_DATA_BREAK_REG_ZERO: data_break_reg_zero <= cp_wdata;
                    `SEL_DATA_BREAK_REG_ONE: data_break_reg_one <= cp_wdata;
                    `SEL_DATA_BREAK_CONTROL: data_break_control <= cp_wdata;
                    default: ;
                endcase
            end
            if (cp_valid && !acc_undef && is_wr && sel_dbg &&
                cp_secondary == `SEL_ZERO) begin
                case (cp_primary)
                    `SEL_TX: tx <= cp_wdata;
                    `SEL_CHK0: chk0 <= cp_wdata;
                    `SEL_CHK1: chk1 <= cp_wdata;
                    `SEL_TXRX_CTRL: txrx_ctrl <= cp_wdata;
                    default: ;
                endcase
            end
            if (wr_valid && wr_word[32]) begin
                rx <= wr_word[31:0];
            end
        end
    end

    // Software-owned fields; processor reset clears them
    always_ff @(posedge clk) begin
        if (reset) begin
            ge <= 1'b0;
            tb_mode <= 1'b0;
        end else if (ce && sw_debug_control_status_wr) begin
            ge <= cp_wdata[`BIT_GE];
            tb_mode <= cp_wdata[`BIT_M];
        end
    end

    // Test-port-owned fields; only test reset clears them
    always_ff @(posedge clk) begin
        if (ce) begin
            if (trst_s2) begin
                halt <= 1'b0;
                {trap_fiq, trap_irq, trap_dab} <= 3'h0;
                {trap_pab, trap_swi, trap_und, trap_rst} <= 4'h0;
            end else if (wr_valid && !wr_word[32]) begin
                halt <= wr_word[`BIT_HALT];
                trap_fiq <= wr_word[`BIT_TF];
                trap_irq <= wr_word[`BIT_TI];
                trap_dab <= wr_word[`BIT_TD];
                trap_pab <= wr_word[`BIT_TA];
                trap_swi <= wr_word[`BIT_TS];
                trap_und <= wr_word[`BIT_TU];
                trap_rst <= wr_word[`BIT_TR];
            end
        end
    end

    // System break level shown in the status word
    always_ff @(posedge clk) begin
        if (reset) begin
            soc_level <= 1'b0;
        end else if (ce) begin
            soc_level <= soc_s2;
        end
    end

    // Vector trap match; reset trap is independent of global enable
    always_comb begin
        case (vec_index)
            `VIDX_RESET: vt_hit = trap_rst;
            `VIDX_UNDEF: vt_hit = trap_und && ge;
            `VIDX_SWI: vt_hit = trap_swi && ge;
            `VIDX_PABORT: vt_hit = trap_pab && ge;
            `VIDX_DABORT: vt_hit = trap_dab && ge;
            `VIDX_IRQ: vt_hit = trap_irq && ge;
            `VIDX_FIQ: vt_hit = trap_fiq && ge;
            default: vt_hit = 1'b0;
        endcase
        vt_hit = vt_hit && vec_fetch;
    end

    // Highest-priority cause; other sources need the global enable
    always_comb begin
        any_exc = 1'b1;
        next_moe = moe;
        if (vt_hit) begin
            next_moe = `MOE_VTRAP;
        end else if (ge && data_break_hit) begin
            next_moe = `MOE_DBRK;
        end else if (ge && soc_edge) begin
            next_moe = `MOE_EXT;
        end else if (ge && trace_full) begin
            next_moe = `MOE_TBFULL;
        end else if (ge && insn_break_hit) begin
            next_moe = `MOE_IBRK;
        end else if (ge && bkpt_insn) begin
            next_moe = `MOE_BKPT;
        end else begin
            any_exc = 1'b0;
        end
    end

    // Entry cause, trace enable and sticky abort; hardware wins over software
    always_ff @(posedge clk) begin
        if (reset) begin
            moe <= `MOE_RESET;
            tb_en <= 1'b0;
            sticky_abort <= 1'b0;
        end else if (ce) begin
            if (any_exc) begin
                moe <= next_moe;
            end else if (sw_debug_control_status_wr) begin
                moe <= cp_wdata[4:2];
            end
            if (any_exc) begin
                tb_en <= 1'b0;
            end else if (sw_debug_control_status_wr) begin
                tb_en <= cp_wdata[`BIT_E];
            end
            if (sds_data_abort && halt) begin
                sticky_abort <= 1'b1;
            end else if (sw_debug_control_status_wr) begin
                sticky_abort <= cp_wdata[`BIT_SA];
            end
        end
    end

    // Exception dispatch: halt uses reset vector, monitor uses aborts
    always_ff @(posedge clk) begin
        if (reset) begin
            exc_take <= 1'b0;
            exc_mode <= `MODE_USER;
            exc_vector <= `VEC_RESET;
        end else if (ce) begin
            exc_take <= any_exc;
            if (any_exc && halt) begin
                exc_mode <= `MODE_DEBUG;
                exc_vector <= `VEC_RESET;
            end else if (any_exc) begin
                exc_mode <= `MODE_ABORT;
                exc_vector <= (next_moe == `MOE_DBRK) ? `VEC_DABORT : `VEC_PABORT;
            end
        end
    end

    // Trace run and cache download permission
    always_ff @(posedge clk) begin
        if (reset) begin
            trace_run <= 1'b0;
            cache_download_en <= 1'b0;
        end else if (ce) begin
            trace_run <= tb_en && ge && !any_exc;
            cache_download_en <= halt;
        end
    end

    AST_USER_UNDEF: assert property (@(posedge clk) disable iff (reset)
        (ce && cp_valid && sel_dbg && cur_mode == `MODE_USER) |=> cp_undef)
        else $error("user access not trapped");
    AST_DATA_OP_UNDEF: assert property (@(posedge clk) disable iff (reset)
        (ce && cp_valid && sel_dbg && cp_op == CP_DATA_OP) |=> (cp_done && cp_undef))
        else $error("data operation not trapped");
    AST_GE_AFTER_RESET: assert property (@(posedge clk)
        $fell(reset) |-> !ge)
        else $error("global enable set after reset");
    AST_TRACE_STOP: assert property (@(posedge clk) disable iff (reset)
        (exc_take && ce) |=> !trace_run)
        else $error("trace still running after exception");
    AST_HALT_VECTOR: assert property (@(posedge clk) disable iff (reset)
        (ce && any_exc && halt) |=> (exc_take && exc_mode == 5'h15 && exc_vector == 5'h00))
        else $error("halt entry wrong");
    AST_MON_DABORT: assert property (@(posedge clk) disable iff (reset)
        (ce && any_exc && !halt && next_moe == 3'h2) |=>
        (exc_mode == 5'h17 && exc_vector == 5'h10))
        else $error("monitor data break wrong");
    AST_DISABLED_QUIET: assert property (@(posedge clk) disable iff (reset)
        (ce && !ge && !(vec_fetch && vec_index == 3'h0)) |=> !exc_take)
        else $error("exception while disabled");
    AST_SOC_LEVEL: assert property (@(posedge clk) disable iff (reset)
        (ce && $past(ce) && $past(ce, 2)) |-> (debug_control_status_word[29] == $past(soc_s1, 2)))
        else $error("break level bit wrong");
    AST_TRST_CLEAR: assert property (@(posedge clk) disable iff (reset)
        (ce && trst_s2) |=> (!halt && !trap_fiq && !trap_irq && !trap_dab))
        else $error("test reset did not clear");
endmodule : debug_control_unit

// *** test/debugger_model.sv ***
// Host debugger model: writes words over the test port, one at a time.
// Assumes tck runs free and tp_busy answers every accepted write.
`timescale 1ns/1ps
module debugger_model
    import debug_unit_pkg::*;
(
    input wire logic tck,
    input wire logic tp_busy,
    output logic tp_write,
    output tp_target_t tp_target,
    output logic [31:0] tp_wdata
);
    // Idle port at time zero
    initial begin
        tp_write = 1'b0;
        tp_target = TP_TO_DEBUG_CONTROL_STATUS;
        tp_wdata = 32'h0000_0000;
    end
    // One write, then a bounded wait for busy to clear; ok low on timeout
    task automatic send(input tp_target_t t, input logic [31:0] d, output bit ok);
        ok = 1'b0;
        @(posedge tck);
        tp_write <= 1'b1;
        tp_target <= t;
        tp_wdata <= d;
        @(posedge tck);
        tp_write <= 1'b0;
        tp_wdata <= ~d; // Released data does not keep its last value
        for (int n = 0; n < 40; n++) begin
            @(negedge tck);
            if (n > 0 && tp_busy === 1'b0) begin
                ok = 1'b1;
                break;
            end
        end
    endtask : send
endmodule : debugger_model

// *** test/test_debug_control_unit.sv ***
// Bench for the debug control unit: register decode, modes, exceptions.
// Assumes the debugger model and the design are compiled before it.
`timescale 1ns/1ps
module test_debug_control_unit;
    import debug_unit_pkg::*;
    logic clk, reset, ce, cp_valid, cp_done, cp_undef, tck, tp_reset, tp_write, tp_busy;
    logic insn_break_hit, data_break_hit, bkpt_insn, trace_full, sds_data_abort;
    logic vec_fetch, soc_break, exc_take, trace_run, cache_download_en, tp_view_valid, und;
    logic [3:0] cp_num, cp_primary, cp_secondary;
    logic [4:0] cur_mode, exc_mode, exc_vector;
    logic [2:0] vec_index;
    logic [31:0] cp_wdata, cp_rdata, tp_wdata, tp_debug_control_status, tp_tx, rd;
    cp_op_t cp_op;
    tp_target_t tp_target;
    int miscompares, compares;
    bit ok;
    // Coprocessor, primary and secondary of the ten storage registers
    logic [3:0] tn [10] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'he, 4'he, 4'he, 4'he, 4'he};
    logic [3:0] tpri [10] = '{4'he, 4'he, 4'he, 4'he, 4'he, 4'h8, 4'h9, 4'hc, 4'hd, 4'he};
    logic [3:0] tsec [10] = '{4'h8, 4'h9, 4'h0, 4'h3, 4'h4, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};

    debug_control_unit dut_u (.*);
    debugger_model host_u (.*);

    // Core clock and unrelated link clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        tck = 1'b0;
        #3;
        forever #24 tck = ~tck;
    end

    task automatic chk(input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    // One access; opcode sub-fields are never presented
    task automatic acc(input cp_op_t op, input logic [3:0] n, p, s,
                       input logic [31:0] wd, input logic [4:0] md);
        @(posedge clk);
        cp_valid <= 1'b1;
        cp_op <= op;
        {cp_num, cp_primary, cp_secondary, cp_wdata, cur_mode} <= {n, p, s, wd, md};
        @(posedge clk);
        cp_valid <= 1'b0;
        @(negedge clk);
        rd = cp_rdata;
        und = cp_undef;
        chk(cp_done, 1'b1);
    endtask : acc

    // Pulse {vector fetch, data, insn, bkpt} and catch the exception answer
    task automatic ev(input logic [3:0] hit, input logic tk, input logic [4:0] md, vc);
        bit seen;
        seen = 1'b0;
        @(posedge clk);
        {vec_fetch, data_break_hit, insn_break_hit, bkpt_insn} <= hit;
        @(posedge clk);
        {vec_fetch, data_break_hit, insn_break_hit, bkpt_insn} <= 4'h0;
        repeat (3) begin
            @(negedge clk);
            if (exc_take === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({exc_mode, exc_vector}, {md, vc});
            end
        end
        chk(seen, tk);
    endtask : ev

    task automatic tpw(input tp_target_t t, input logic [31:0] d);
        host_u.send(t, d, ok);
        if (!ok) begin
            miscompares++;
            tally_and_finish();
        end
    endtask : tpw

    initial begin
        #200000;
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {reset, tp_reset, ce, cp_valid, insn_break_hit, data_break_hit} = 6'b111_000;
        {bkpt_insn, trace_full, sds_data_abort, vec_fetch, soc_break} = 5'b0_0000;
        {cp_num, cp_primary, cp_secondary, cp_wdata, cur_mode} = 49'h0;
        cp_op = CP_READ;
        vec_index = 3'h4;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (6) @(posedge tck);
        tp_reset <= 1'b0;
        repeat (5) @(posedge tck);
        @(posedge clk);
        soc_break <= 1'b1;
        ev(4'h1, 1'b0, 5'h00, 5'h00);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h13);
        chk(rd, 32'h2000_0000);
        @(posedge clk);
        soc_break <= 1'b0;
        acc(CP_WRITE, 4'he, 4'ha, 4'h0, 32'hffff_ffff, 5'h13);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h13);
        chk(rd, 32'h8000_003f);
        chk(trace_run, 1'b1);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h10);
        chk(und, 1'b1);
        acc(CP_DATA_OP, 4'he, 4'h8, 4'h0, 32'h0, 5'h13);
        chk(und, 1'b1);
        for (int i = 0; i < 10; i++)
            acc(CP_WRITE, tn[i], tpri[i], tsec[i], 32'h5a00_0000 + i, 5'h13);
        for (int i = 0; i < 10; i++) begin
            acc(CP_READ, tn[i], tpri[i], tsec[i], 32'h0, 5'h13);
            // Receive register is loaded only from the test port
            chk(rd, (i == 6) ? 32'h0000_0000 : 32'h5a00_0000 + i);
        end
        tpw(TP_TO_DEBUG_CONTROL_STATUS, 32'h40d0_0000);
        tpw(TP_TO_RX, 32'h1234_5678);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h13);
        chk(und, 1'b1);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h15);
        chk(rd, 32'hc0d0_003f);
        acc(CP_READ, 4'he, 4'h9, 4'h0, 32'h0, 5'h15);
        chk(rd, 32'h1234_5678);
        // Wait for a fresh view word, bounded
        for (int n = 0; n < 20 && tp_view_valid !== 1'b1; n++)
            @(negedge tck);
        chk(tp_view_valid, 1'b1);
        chk(tp_debug_control_status, 32'hc0d0_003f);
        chk(tp_tx, 32'h5a00_0005);
        chk(cache_download_en, 1'b1);
        ev(4'h8, 1'b1, 5'h15, 5'h00);
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h15);
        chk(rd, 32'hc0d0_0036);
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h15);
        chk(rd, 32'h40d0_0000);
        @(posedge tck);
        tp_reset <= 1'b1;
        repeat (5) @(posedge tck);
        tp_reset <= 1'b0;
        repeat (5) @(posedge tck);
        acc(CP_WRITE, 4'he, 4'ha, 4'h0, 32'h8000_0000, 5'h13);
        ev(4'h4, 1'b1, 5'h17, 5'h10);
        ev(4'h2, 1'b1, 5'h17, 5'h0c);
        // Frozen core must ignore a data break
        @(posedge clk);
        ce <= 1'b0;
        ev(4'h4, 1'b0, 5'h17, 5'h10);
        @(posedge clk);
        ce <= 1'b1;
        acc(CP_READ, 4'he, 4'ha, 4'h0, 32'h0, 5'h13);
        chk(rd, 32'h8000_0004);
        tally_and_finish();
    end
endmodule : test_debug_control_unit
